/* cch_top.sv */
// Configuration command handler: frame decode, map sequencer, reply frames, register slave
// What this block does
// - Command 0x05 in byte three selects trip-2 setting for channel 0x01..0x0C.
// - Byte five 0x00 keeps trip 2 active, 0x01 deactivates it.
// - Byte one high nibble is message ID, low nibble plus byte two manufacturer code.
// - Command 0x04 restores defaults; bytes four to eight must be zero.
// - Delivered node address is 0xA0.
// - Default rated current 30 A channels 1-4, 10 A channels 5-12; delivered and restored rated codes are 0 for all twelve channels.
// - Default on/off delays zero, fast disconnection active.
// - Restore defaults leaves the node address unchanged.
// - Whole configuration kept in nonvolatile storage across power loss.
// - Two map bytes per channel from 0x60; rated codes two per byte from 0x78.
// - Query uses message ID three, command 0x02, zeros elsewhere.
// - A query is answered by four reply frames mirroring stored bytes.
// - First reply ID 0x18FF10 plus node address, carrying bytes 0x60..0x67.
// - Reply frames follow within at most 100 ms of each other.
// - Commands are 8-byte extended frames, ID 0x18EF, node, sender.
// - Command 0x03 changes node address to byte four.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cch_top #(
   parameter int TX_INTERVAL_CYC = cch_pkg::TX_INTERVAL_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic rx_ext,
   input wire logic [3:0] rx_dlc,
   input wire logic [28:0] rx_id,
   input wire logic [63:0] rx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [28:0] tx_id,
   output logic [3:0] tx_dlc,
   output logic [63:0] tx_data
);
   cch_pkg::cch_state_t state;
   cch_pkg::cch_state_t next_state;
   logic [7:0] rb [1:8];
   logic [7:0] node_addr;
   logic [5:0] cmd_addr;
   logic [7:0] cmd_val;
   logic [5:0] ch_idx;
   logic [1:0] q_frame;
   logic [2:0] q_byte;
   logic [22:0] q_wait;
   logic q_cap;
   logic frame_ok, is_cfg, is_qry, tail_zero;
   logic do_trip, do_def, do_node, do_qry, cmd_ok, take, q_tmo;
   logic ctrl_en, stat_tmo;
   logic [15:0] accept_cnt, reject_cnt;
   logic aw_held, w_held;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_fire;
   logic [31:0] status_word;

   cch_nv_if nv();
   cch_nv_store u_store (
      .clk(clk),
      .nv(nv)
   );

   // ==========================================================
   // Frame decode
   for (genvar k = 1; k <= 8; k++) begin : g_byte
      assign rb[k] = rx_data[8*k-1 -: 8];
   end

   assign frame_ok = rx_ext && rx_dlc == cch_pkg::DLC_FULL && rx_id[28:16] == cch_pkg::CMD_ID_HI
                     && rx_id[15:8] == node_addr;
   assign is_cfg = frame_ok && rb[1][7:4] == cch_pkg::MSG_CFG && rb[1][3:0] == cch_pkg::MFR_CODE[11:8]
                   && rb[2] == cch_pkg::MFR_CODE[7:0];
   assign is_qry = frame_ok && rb[1][7:4] == cch_pkg::MSG_QRY && rb[1][3:0] == cch_pkg::MFR_CODE[11:8]
                   && rb[2] == cch_pkg::MFR_CODE[7:0];
   assign tail_zero = {rb[4], rb[5], rb[6], rb[7], rb[8]} == 40'h00_0000_0000;
   assign do_trip = is_cfg && rb[3] == cch_pkg::OP_TRIP && rb[4] >= cch_pkg::CH_MIN
                    && rb[4] <= cch_pkg::CH_MAX && rb[5] <= cch_pkg::TRIP_VAL_MAX;
   assign do_def = is_cfg && rb[3] == cch_pkg::OP_DEF && tail_zero;
   assign do_node = is_cfg && rb[3] == cch_pkg::OP_NODE && rb[4] >= cch_pkg::NODE_MIN
                    && rb[4] <= cch_pkg::NODE_MAX;
   assign do_qry = is_qry && rb[3] == cch_pkg::OP_QUERY && tail_zero;
   // Disabling command processing still drains frames so the link never stalls
   assign cmd_ok = ctrl_en && (do_trip || do_def || do_node || do_qry);
   assign take = rx_valid && rx_ready;
   assign rx_ready = state == cch_pkg::S_IDLE;
   assign ch_idx = cch_pkg::NV_CH_IDX + {rb[4][4:0], 1'b0} - 6'h02;
   assign tx_valid = state == cch_pkg::S_Q_SEND;
   assign q_tmo = q_wait == 23'(TX_INTERVAL_CYC - 1);

   // ==========================================================
   // Sequencer
   always_comb begin
      next_state = state;
      case (state)
         cch_pkg::S_LOAD_RD: begin
            next_state = cch_pkg::S_LOAD_CAP;
         end
         cch_pkg::S_LOAD_CAP: begin
            next_state = cch_pkg::S_IDLE;
         end
         cch_pkg::S_IDLE: begin
            if (take && cmd_ok) begin
               if (do_trip) begin
                  next_state = cch_pkg::S_TRIP_RD;
               end else if (do_def) begin
                  next_state = cch_pkg::S_DEF_WR;
               end else if (do_node) begin
                  next_state = cch_pkg::S_NODE_WR;
               end else begin
                  next_state = cch_pkg::S_Q_RD;
               end
            end
         end
         cch_pkg::S_TRIP_RD: begin
            next_state = cch_pkg::S_TRIP_WR;
         end
         cch_pkg::S_TRIP_WR, cch_pkg::S_NODE_WR: begin
            next_state = cch_pkg::S_IDLE;
         end
         cch_pkg::S_DEF_WR: begin
            if (cmd_addr == cch_pkg::DEF_LAST_IDX) begin
               next_state = cch_pkg::S_IDLE;
            end
         end
         cch_pkg::S_Q_RD: begin
            if (q_cap && q_byte == cch_pkg::LAST_BYTE) begin
               next_state = cch_pkg::S_Q_SEND;
            end
         end
         cch_pkg::S_Q_SEND: begin
            if (tx_ready && q_frame == cch_pkg::LAST_FRAME) begin
               next_state = cch_pkg::S_IDLE;
            end else if (tx_ready) begin
               next_state = cch_pkg::S_Q_RD;
            end else if (q_tmo) begin
               next_state = cch_pkg::S_IDLE;
            end
         end
         default: begin
            next_state = cch_pkg::S_LOAD_RD;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= cch_pkg::S_LOAD_RD;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // Store access
   always_comb begin
      nv.en = 1'b0;
      nv.we = 1'b0;
      nv.addr = cmd_addr;
      nv.wdata = cmd_val;
      case (state)
         cch_pkg::S_LOAD_RD: begin
            nv.en = 1'b1;
            nv.addr = cch_pkg::NV_NODE_IDX;
         end
         cch_pkg::S_TRIP_RD: begin
            nv.en = 1'b1;
         end
         cch_pkg::S_TRIP_WR: begin
            nv.en = 1'b1;
            nv.we = 1'b1;
            nv.wdata = {cmd_val[0], nv.rdata[6:0]};
         end
         cch_pkg::S_NODE_WR: begin
            nv.en = 1'b1;
            nv.we = 1'b1;
            nv.addr = cch_pkg::NV_NODE_IDX;
         end
         cch_pkg::S_DEF_WR: begin
            nv.en = 1'b1;
            nv.we = 1'b1;
            // Node byte lies below the fill range, so it survives a restore
            nv.wdata = (cmd_addr >= cch_pkg::NV_RATED_IDX) ? cch_pkg::DEF_RATED_BYTE
                       : cch_pkg::DEF_CH_BYTE;
         end
         cch_pkg::S_Q_RD: begin
            nv.en = !q_cap;
            nv.addr = cch_pkg::NV_REPLY_IDX + 6'({q_frame, q_byte});
         end
         default: begin
            nv.en = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_addr <= 6'h00;
         cmd_val <= 8'h00;
      end else if (take && cmd_ok) begin
         cmd_addr <= do_trip ? ch_idx : cch_pkg::NV_CH_IDX;
         cmd_val <= do_trip ? rb[5] : rb[4];
      end else if (state == cch_pkg::S_DEF_WR) begin
         cmd_addr <= cmd_addr + 6'h01;
      end
   end

   // Node address takes effect only when reloaded after a reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         node_addr <= cch_pkg::NODE_DEFAULT;
      end else if (state == cch_pkg::S_LOAD_CAP) begin
         node_addr <= nv.rdata;
      end
   end

   // ==========================================================
   // Reply frames
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q_frame <= 2'd0;
         q_byte <= 3'd0;
         q_cap <= 1'b0;
      end else if (state == cch_pkg::S_IDLE) begin
         q_frame <= 2'd0;
         q_byte <= 3'd0;
         q_cap <= 1'b0;
      end else if (state == cch_pkg::S_Q_RD) begin
         q_cap <= !q_cap;
         if (q_cap && q_byte != cch_pkg::LAST_BYTE) begin
            q_byte <= q_byte + 3'd1;
         end
      end else if (state == cch_pkg::S_Q_SEND && tx_ready) begin
         q_frame <= q_frame + 2'd1;
         q_byte <= 3'd0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q_wait <= 23'h00_0000;
      end else if (state == cch_pkg::S_Q_SEND && !tx_ready) begin
         q_wait <= q_wait + 23'h00_0001;
      end else begin
         q_wait <= 23'h00_0000;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_data <= 64'h0;
         tx_id <= 29'h0;
         tx_dlc <= 4'h0;
      end else if (state == cch_pkg::S_Q_RD && q_cap) begin
         tx_data[{q_byte, 3'b000} +: 8] <= nv.rdata;
         tx_id <= {cch_pkg::REPLY_ID_HI + 21'(q_frame), node_addr};
         tx_dlc <= cch_pkg::DLC_FULL;
      end
   end

   // ==========================================================
   // Counters and status
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         accept_cnt <= 16'h0000;
         reject_cnt <= 16'h0000;
      end else if (take && cmd_ok) begin
         accept_cnt <= accept_cnt + 16'h0001;
      end else if (take) begin
         reject_cnt <= reject_cnt + 16'h0001;
      end
   end

   // Timeout set wins over a software clear in the same cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat_tmo <= 1'b0;
      end else if (tx_valid && !tx_ready && q_tmo) begin
         stat_tmo <= 1'b1;
      end else if (wr_fire && aw_addr_q == cch_pkg::REG_STATUS && w_strb_q[0] && w_data_q[cch_pkg::STAT_TMO_BIT]) begin
         stat_tmo <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_en <= cch_pkg::CTRL_EN_RESET;
      end else if (wr_fire && aw_addr_q == cch_pkg::REG_CTRL && w_strb_q[0]) begin
         ctrl_en <= w_data_q[cch_pkg::CTRL_EN_BIT];
      end
   end

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[cch_pkg::STAT_BUSY_BIT] = state != cch_pkg::S_IDLE;
      status_word[cch_pkg::STAT_TMO_BIT] = stat_tmo;
      status_word[cch_pkg::STAT_NODE_LSB +: 8] = node_addr;
   end

   // ==========================================================
   // AXI4-Lite slave
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_held <= 1'b0;
         aw_addr_q <= 8'h00;
         w_held <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= cch_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (aw_addr_q == cch_pkg::REG_CTRL || aw_addr_q == cch_pkg::REG_STATUS)
                        ? cch_pkg::RESP_OKAY : cch_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= cch_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= cch_pkg::RESP_OKAY;
         case (s_axi_araddr)
            cch_pkg::REG_CTRL: s_axi_rdata <= {31'h0000_0000, ctrl_en};
            cch_pkg::REG_STATUS: s_axi_rdata <= status_word;
            cch_pkg::REG_ACCEPT: s_axi_rdata <= {16'h0000, accept_cnt};
            cch_pkg::REG_REJECT: s_axi_rdata <= {16'h0000, reject_cnt};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= cch_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_trip_cmd;
      take && cmd_ok && do_trip;
   endsequence
   sequence s_def_cmd;
      take && cmd_ok && do_def;
   endsequence
   sequence s_qry_cmd;
      take && cmd_ok && do_qry;
   endsequence

   property p_trip_write;
      s_trip_cmd |-> ##2 (nv.we && nv.addr == $past(ch_idx, 2) && nv.wdata[cch_pkg::TRIP_BIT] == $past(rb[5][0], 2));
   endproperty
   a_trip_write: assert property (p_trip_write) else $error("trip setting not written");

   property p_bad_ignored;
      take && !cmd_ok |=> !nv.we && state == cch_pkg::S_IDLE;
   endproperty
   a_bad_ignored: assert property (p_bad_ignored) else $error("bad frame changed store");

   property p_reject_count;
      take && !frame_ok |=> reject_cnt == $past(reject_cnt) + 16'h0001;
   endproperty
   a_reject_count: assert property (p_reject_count) else $error("foreign frame not rejected");

   property p_default_fill;
      s_def_cmd |=> (nv.we && nv.wdata == cch_pkg::DEF_CH_BYTE && nv.addr != cch_pkg::NV_NODE_IDX) [*8];
   endproperty
   a_default_fill: assert property (p_default_fill) else $error("default fill wrong");

   property p_node_stable;
      state != cch_pkg::S_LOAD_CAP |=> $stable(node_addr);
   endproperty
   a_node_stable: assert property (p_node_stable) else $error("node address changed live");

   property p_node_change;
      take && cmd_ok && do_node |=> nv.we && nv.addr == cch_pkg::NV_NODE_IDX && nv.wdata == $past(rb[4]);
   endproperty
   a_node_change: assert property (p_node_change) else $error("node change not stored");

   property p_first_reply;
      tx_valid && q_frame == 2'd0 |-> tx_id == {cch_pkg::REPLY_ID_HI, node_addr} && tx_dlc == cch_pkg::DLC_FULL;
   endproperty
   a_first_reply: assert property (p_first_reply) else $error("first reply id wrong");

   property p_query_start;
      s_qry_cmd |-> ##[2:20] tx_valid;
   endproperty
   a_query_start: assert property (p_query_start) else $error("query not answered");

   property p_interval;
      tx_valid && !tx_ready && q_tmo |=> !tx_valid && stat_tmo;
   endproperty
   a_interval: assert property (p_interval) else $error("reply interval overrun");

   property p_tx_hold;
      tx_valid && !tx_ready && !q_tmo |=> tx_valid && $stable(tx_data) && $stable(tx_id);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("reply frame changed while waiting");
endmodule
`default_nettype wire

/* cch_pkg.sv */
// Constants, map layout and state encoding of the configuration command handler
package cch_pkg;
   // ==========================================================
   // Command frame identification
   localparam logic [12:0] CMD_ID_HI = 13'h18ef;
   localparam logic [20:0] REPLY_ID_HI = 21'h18ff10;
   localparam logic [3:0] MSG_CFG = 4'h6;
   localparam logic [3:0] MSG_QRY = 4'h3;
   // Arbitrary manufacturer code, not any real maker's value
   localparam logic [11:0] MFR_CODE = 12'h5a7;
   localparam logic [3:0] DLC_FULL = 4'h8;
   // ==========================================================
   // Command codes and value ranges
   localparam logic [7:0] OP_QUERY = 8'h02;
   localparam logic [7:0] OP_NODE = 8'h03;
   localparam logic [7:0] OP_DEF = 8'h04;
   localparam logic [7:0] OP_TRIP = 8'h05;
   localparam logic [7:0] CH_MIN = 8'h01;
   localparam logic [7:0] CH_MAX = 8'h0c;
   localparam logic [7:0] NODE_MIN = 8'h01;
   localparam logic [7:0] NODE_MAX = 8'hfd;
   localparam logic [7:0] TRIP_VAL_MAX = 8'h01;
   localparam logic [7:0] NODE_DEFAULT = 8'ha0;
   // ==========================================================
   // Nonvolatile map: index = map byte address - 0x40
   localparam int NV_DEPTH = 64;
   localparam logic [5:0] NV_NODE_IDX = 6'h1f;
   localparam logic [5:0] NV_CH_IDX = 6'h20;
   localparam logic [5:0] NV_REPLY_IDX = 6'h20;
   localparam logic [5:0] NV_RATED_IDX = 6'h38;
   localparam logic [5:0] DEF_LAST_IDX = 6'h3d;
   localparam int TRIP_BIT = 7;
   localparam logic TRIP_ACTIVE = 1'b0;
   localparam logic [6:0] DELAY_DEFAULT = 7'h00;
   localparam logic [3:0] RATED_DEFAULT = 4'h0;
   localparam logic [7:0] DEF_CH_BYTE = {TRIP_ACTIVE, DELAY_DEFAULT};
   localparam logic [7:0] DEF_RATED_BYTE = {RATED_DEFAULT, RATED_DEFAULT};
   localparam logic [1:0] LAST_FRAME = 2'd3;
   localparam logic [2:0] LAST_BYTE = 3'd7;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 50_000_000;
   localparam int TX_INTERVAL_MS = 100;
   localparam int TX_INTERVAL_CYC = (CLK_HZ / 1000) * TX_INTERVAL_MS;
   // ==========================================================
   // Register bus map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_ACCEPT = 8'h08;
   localparam logic [7:0] REG_REJECT = 8'h0c;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RESET = 1'b1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_TMO_BIT = 1;
   localparam int STAT_NODE_LSB = 8;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ==========================================================
   // Sequencer states
   typedef enum logic [8:0] {
      S_LOAD_RD  = 9'h001,
      S_LOAD_CAP = 9'h002,
      S_IDLE     = 9'h004,
      S_TRIP_RD  = 9'h008,
      S_TRIP_WR  = 9'h010,
      S_NODE_WR  = 9'h020,
      S_DEF_WR   = 9'h040,
      S_Q_RD     = 9'h080,
      S_Q_SEND   = 9'h100
   } cch_state_t;
endpackage

/* cch_nv_if.sv */
// Port bundle between the sequencer and the nonvolatile store
`timescale 1ns/1ps
`default_nettype none
interface cch_nv_if;
   logic en;
   logic we;
   logic [5:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl(output en, output we, output addr, output wdata, input rdata);
   modport store(input en, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* cch_nv_store.sv */
// Nonvolatile configuration store with registered read data
`timescale 1ns/1ps
`default_nettype none
module cch_nv_store (
   input wire logic clk,
   cch_nv_if.store nv
);
   logic [7:0] mem [cch_pkg::NV_DEPTH];

   // ==========================================================
   // Delivered contents; no reset, so settings outlive sys_rst
   initial begin
      for (int i = 0; i < cch_pkg::NV_DEPTH; i++) begin
         mem[i] = 8'h00;
      end
      mem[cch_pkg::NV_NODE_IDX] = cch_pkg::NODE_DEFAULT;
   end

   always_ff @(posedge clk) begin
      if (nv.en && nv.we) begin
         mem[nv.addr] <= nv.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (nv.en && !nv.we) begin
         nv.rdata <= mem[nv.addr];
      end
   end
endmodule
`default_nettype wire

/* cch_ecu.sv */
// Supervising ECU model: sends command frames and takes reply frames
`timescale 1ns/1ps
`default_nettype none
module cch_ecu (
   input wire logic clk,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic rx_ext,
   output logic [3:0] rx_dlc,
   output logic [28:0] rx_id,
   output logic [63:0] rx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [28:0] tx_id,
   input wire logic [3:0] tx_dlc,
   input wire logic [63:0] tx_data
);
   logic [96:0] got[$];
   // Stall forces a reply timeout; ext and dlc let the bench send malformed frames
   logic stall = 1'b0;
   logic ext = 1'b1;
   logic [3:0] dlc = 4'h8;
   initial begin
      {rx_valid, rx_dlc, rx_id, rx_data, tx_ready} = '0;
      rx_ext = 1'b1;
   end
   // ======
   // Frame held until taken; data inverted after release so stale bytes never look valid
   task automatic send(input logic [28:0] id, input logic [63:0] d);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_id <= id;
      rx_data <= d;
      rx_dlc <= dlc;
      rx_ext <= ext;
      do @(posedge clk); while (rx_ready !== 1'b1);
      rx_valid <= 1'b0;
      rx_data <= ~d;
   endtask
   // Random stalls stay far inside the reply interval
   always @(posedge clk) begin
      if (tx_valid && tx_ready)
         got.push_back({tx_dlc, tx_id, tx_data});
      tx_ready <= !stall && ($urandom_range(3) == 0);
   end
endmodule
`default_nettype wire

/* test_cch_top.sv */
// Self-checking bench of the configuration command handler
`timescale 1ns/1ps
`default_nettype none
module test_cch_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] s_axi_awaddr = '0;
   logic [7:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_valid, rx_ready, rx_ext;
   logic tx_valid, tx_ready;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rd;
   logic [3:0] rx_dlc, tx_dlc;
   logic [28:0] rx_id, tx_id;
   logic [63:0] rx_data, tx_data;
   logic [96:0] fr;
   logic [7:0] node = 8'ha0;
   int n_fail = 0, checks_done = 0, acc = 0, rej = 0, ch, v;
   int nv[64];
   cch_top #(.TX_INTERVAL_CYC(64)) dut (.*);
   cch_ecu ecu (.*);
   always #10 clk = ~clk;
   // ======
   // Checking and bus tasks
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic cmd(input logic [3:0] m, input logic [7:0] op, b4, b5, dst, input bit ok);
      ecu.send({cch_pkg::CMD_ID_HI, dst, 8'h64},
         {24'h0, b5, b4, op, cch_pkg::MFR_CODE[7:0], m, cch_pkg::MFR_CODE[11:8]});
      if (ok) acc++;
      else rej++;
   endtask
   // Reply frames must mirror the model map byte for byte
   task automatic query();
      cmd(cch_pkg::MSG_QRY, cch_pkg::OP_QUERY, 8'h0, 8'h0, node, 1);
      for (int i = 0; i < 2000 && ecu.got.size() < 4; i++) @(posedge clk);
      chk(ecu.got.size(), 4);
      for (int f = 0; f < 4 && ecu.got.size() > 0; f++) begin
         fr = ecu.got.pop_front();
         chk(fr[96:64], {4'h8, cch_pkg::REPLY_ID_HI + 21'(f), node});
         for (int k = 0; k < 8; k++) chk(fr[8*k+:8], nv[32+8*f+k]);
      end
   endtask
   task automatic restore();
      cmd(cch_pkg::MSG_CFG, cch_pkg::OP_DEF, 8'h0, 8'h0, node, 1);
      for (int i = 32; i < 62; i++) nv[i] = 0;
      // Settle time before any reset, scaled from seconds down to cycles
      repeat (40) @(posedge clk);
   endtask
   // Store survives reset; node register reloads from it
   task automatic rst_pulse();
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      node = 8'(nv[31]);
      repeat (5) @(posedge clk);
      axr(cch_pkg::REG_STATUS);
      chk(rd[15:8], node);
   endtask
   // ======
   // Main sequence
   initial begin
      void'($urandom(32'h95a9));
      nv[31] = 'ha0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (5) @(posedge clk);
      axr(cch_pkg::REG_STATUS);
      chk(rd[15:8], 8'ha0);
      axr(cch_pkg::REG_CTRL);
      chk(rd, 32'h1);
      query();
      for (int i = 0; i < 8; i++) begin
         ch = (i == 0) ? 1 : (i == 1) ? 12 : $urandom_range(12, 1);
         v = $urandom_range(1);
         cmd(cch_pkg::MSG_CFG, cch_pkg::OP_TRIP, 8'(ch), 8'(v), node, 1);
         nv[30+2*ch] = (nv[30+2*ch] & 'h7f) | (v << 7);
      end
      cmd(cch_pkg::MSG_CFG, cch_pkg::OP_TRIP, 8'h0, 8'h1, node, 0);
      cmd(cch_pkg::MSG_CFG, cch_pkg::OP_TRIP, 8'hd, 8'h1, node, 0);
      cmd(cch_pkg::MSG_QRY, cch_pkg::OP_TRIP, 8'h1, 8'h1, node, 0);
      cmd(cch_pkg::MSG_CFG, cch_pkg::OP_TRIP, 8'h1, 8'h1, node ^ 8'h1, 0);
      ecu.dlc = 4'h7;
      cmd(cch_pkg::MSG_CFG, cch_pkg::OP_TRIP, 8'h1, 8'h1, node, 0);
      ecu.dlc = 4'h8;
      ecu.ext = 1'b0;
      cmd(cch_pkg::MSG_CFG, cch_pkg::OP_TRIP, 8'h1, 8'h1, node, 0);
      ecu.ext = 1'b1;
      axw(cch_pkg::REG_CTRL, 32'h0);
      cmd(cch_pkg::MSG_CFG, cch_pkg::OP_TRIP, 8'h2, 8'h1, node, 0);
      axw(cch_pkg::REG_CTRL, 32'h1);
      query();
      axr(cch_pkg::REG_ACCEPT);
      chk(rd, acc);
      axr(cch_pkg::REG_REJECT);
      chk(rd, rej);
      axw(8'h10, 32'h1);
      chk(resp, cch_pkg::RESP_SLVERR);
      axr(8'h10);
      chk({resp, rd}, {cch_pkg::RESP_SLVERR, 32'h0});
      restore();
      query();
      cmd(cch_pkg::MSG_CFG, cch_pkg::OP_NODE, 8'h55, 8'h0, node, 1);
      nv[31] = 'h55;
      query();
      rst_pulse();
      cmd(cch_pkg::MSG_CFG, cch_pkg::OP_TRIP, 8'h3, 8'h1, node, 1);
      nv[36] = 'h80;
      restore();
      rst_pulse();
      query();
      // Far side stops taking replies: the query must be abandoned and flagged
      ecu.stall <= 1'b1;
      cmd(cch_pkg::MSG_QRY, cch_pkg::OP_QUERY, 8'h0, 8'h0, node, 1);
      repeat (120) @(posedge clk);
      ecu.stall <= 1'b0;
      axr(cch_pkg::REG_STATUS);
      chk(rd[1:0], 2'b10);
      axw(cch_pkg::REG_STATUS, 32'h2);
      axr(cch_pkg::REG_STATUS);
      chk(rd[1:0], 2'b00);
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
endmodule
`default_nettype wire
